// file: src/sbt_pkg.sv
`default_nettype none

package sbt_pkg;

  // register byte offsets
  localparam logic [4:0] OFF_TX_NIBBLE   = 5'h00;
  localparam logic [4:0] OFF_LENGTH_LOW  = 5'h04;
  localparam logic [4:0] OFF_LENGTH_HIGH = 5'h08;
  localparam logic [4:0] OFF_SERIAL_RATE = 5'h0c;
  localparam logic [4:0] OFF_STATUS      = 5'h10;

  // length_high_ctrl_reg fields
  localparam int BIT_AUTO_SEL = 3;
  localparam int BIT_ISTART   = 2;
  // serial_rate_reg fields
  localparam int BIT_SBE      = 3;
  // status fields
  localparam int BIT_FLAG3    = 0;
  localparam int BIT_EMPTY    = 1;
  localparam int BIT_BUSY     = 2;
  localparam int BIT_TX_FULL  = 3;

  // reset values
  localparam logic [3:0] RST_TX_NIBBLE = 4'hf;
  localparam logic [5:0] RST_SIZE      = 6'h00;
  localparam logic [1:0] RST_RATE      = 2'h0;

  // index of the last bit of a nibble
  localparam logic [1:0] LAST_BIT      = 2'h3;

  typedef enum logic [1:0] {
    SBT_IDLE,
    SBT_INTERACTIVE,
    SBT_AUTO
  } sbt_mode_t;

  typedef struct packed {
    logic        wreq;
    logic [31:0] rdata;
    logic [3:0]  tx_nib;
    logic        tx_full;
    logic [5:0]  size;
    logic        auto_sel;
    logic        istart;
    logic [1:0]  rate;
    logic        sbe;
    sbt_mode_t   mode;
    logic [3:0]  shift;
    logic [1:0]  bit_cnt;
    logic        from_ram;
    logic [5:0]  ram_addr;
    logic        sclk;
    logic        sdata;
    logic        oe;
    logic        flag3;
    logic        empty_irq;
    logic        irq_block;
    logic        irq_restore;
    logic        wake;
    logic        wake_vector;
    logic        irq_seen;
    logic [3:0]  tap_s1;
    logic [3:0]  tap_s2;
    logic        tap_d;
  } sbt_state_t;

  localparam sbt_state_t SBT_RESET = '{
    wreq:        1'b1,
    rdata:       32'h0000_0000,
    tx_nib:      RST_TX_NIBBLE,
    tx_full:     1'b0,
    size:        RST_SIZE,
    auto_sel:    1'b0,
    istart:      1'b0,
    rate:        RST_RATE,
    sbe:         1'b0,
    mode:        SBT_IDLE,
    shift:       4'h0,
    bit_cnt:     2'h0,
    from_ram:    1'b0,
    ram_addr:    6'h00,
    sclk:        1'b0,
    sdata:       1'b0,
    oe:          1'b0,
    flag3:       1'b0,
    empty_irq:   1'b0,
    irq_block:   1'b0,
    irq_restore: 1'b0,
    wake:        1'b0,
    wake_vector: 1'b0,
    irq_seen:    1'b0,
    tap_s1:      4'h0,
    tap_s2:      4'h0,
    tap_d:       1'b0
  };

endpackage : sbt_pkg

`default_nettype wire

// file: src/sbt_serial_write_buffer.sv
// Summary of operation
// - auto mode sends 8 to 256 bits, at rates up to the fastest tap.
// - auto selected plus cpu halt starts automatic transmission.
// - auto sends tx nibble first, then RAM 00 up to last index.
// - global interrupt enable held off during auto, restored at end.
// - auto end sets flag3, clears auto select, wakes cpu, restores interrupts.
// - last index up to 3E gives 64 nibbles; index 00 gives two.
// - cpu resumes after halt, or vectors if an irq came meanwhile.
// - flag3 stays high until tx nibble written; software dummy-writes it.
// - reloading registers and halting again resends the same RAM data.
// - interactive streams any length; gap-free only at two slowest taps.
// - interactive move into shift register raises empty irq and flag3.
// - reload before last bit ends chains the next nibble without gap.
// - any tx nibble write clears empty irq and flag3 except in a cycle that sets them.
// - serial clock on port D bit 0, data on port D bit 1.
// - data changes on serial clock rising edge.
// - rate 00 ck11, 01 ck12, 10 ck14, 11 ck15.
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sbt_serial_write_buffer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // prescaler taps ck11, ck12, ck14, ck15
  input  wire logic [3:0]  ck_tap,
  // cpu core
  input  wire logic        cpu_halt,
  input  wire logic        irq_request,
  output logic             global_irq_block,
  output logic             global_irq_restore,
  output logic             cpu_wake,
  output logic             cpu_wake_vector,
  output logic             branch_test_flag3,
  output logic             tx_empty_irq,
  // ram read port
  output logic      [5:0]  ram_addr,
  input  wire logic [3:0]  ram_rdata,
  // port D pins
  output logic             pd0_sclk_out,
  output logic             pd0_sclk_oe,
  output logic             pd1_sdata_out,
  output logic             pd1_sdata_oe
);

  sbt_pkg::sbt_state_t s;
  sbt_pkg::sbt_state_t next_s;

  always_comb begin
    logic       take_rd;
    logic       take_wr;
    logic       tap_now;
    logic       tap_rise;
    logic       tap_fall;
    logic       ev_flag;
    logic       ev_irq;
    logic [3:0] wd;
    take_rd  = 1'b0;
    take_wr  = 1'b0;
    tap_now  = 1'b0;
    tap_rise = 1'b0;
    tap_fall = 1'b0;
    ev_flag  = 1'b0;
    ev_irq   = 1'b0;
    wd       = avs_writedata[3:0];
    next_s   = s;

    // bus handshake: one wait cycle, then the request is taken
    next_s.wreq = 1'b1;
    if ((avs_read || avs_write) && s.wreq) begin
      next_s.wreq = 1'b0;
    end
    take_rd = avs_read && !s.wreq;
    take_wr = avs_write && !s.wreq;
    if (avs_read && s.wreq) begin
      case (avs_address)
        sbt_pkg::OFF_TX_NIBBLE:   next_s.rdata = {28'h0, s.tx_nib};
        sbt_pkg::OFF_LENGTH_LOW:  next_s.rdata = {28'h0, s.size[3:0]};
        sbt_pkg::OFF_LENGTH_HIGH: next_s.rdata = {28'h0, s.auto_sel, s.istart, s.size[5:4]};
        sbt_pkg::OFF_SERIAL_RATE: next_s.rdata = {28'h0, s.sbe, 1'b0, s.rate};
        sbt_pkg::OFF_STATUS:      next_s.rdata = {28'h0, s.tx_full, s.mode != sbt_pkg::SBT_IDLE,
                                                  s.empty_irq, s.flag3};
        default:                  next_s.rdata = 32'h0000_0000;
      endcase
    end

    // tap synchronisers and edge detection
    next_s.tap_s1 = ck_tap;
    next_s.tap_s2 = s.tap_s1;
    tap_now       = s.tap_s2[s.rate];
    next_s.tap_d  = tap_now;
    tap_rise      = tap_now && !s.tap_d;
    tap_fall      = !tap_now && s.tap_d;

    next_s.wake        = 1'b0;
    next_s.irq_restore = 1'b0;
    if (s.mode == sbt_pkg::SBT_AUTO && irq_request) begin
      next_s.irq_seen = 1'b1;
    end

    case (s.mode)
      sbt_pkg::SBT_IDLE: begin
        next_s.sclk = 1'b0;
        if (s.sbe && s.auto_sel && cpu_halt) begin
          next_s.mode     = sbt_pkg::SBT_AUTO;
          next_s.shift    = s.tx_nib;
          next_s.bit_cnt  = 2'h0;
          next_s.from_ram = 1'b0;
          next_s.ram_addr = 6'h00;
          next_s.irq_seen = irq_request;
        end else if (s.sbe && s.istart) begin
          next_s.mode    = sbt_pkg::SBT_INTERACTIVE;
          next_s.shift   = s.tx_nib;
          next_s.bit_cnt = 2'h0;
          next_s.tx_full = 1'b0;
          ev_flag        = 1'b1;
          ev_irq         = 1'b1;
        end
      end
      sbt_pkg::SBT_INTERACTIVE,
      sbt_pkg::SBT_AUTO: begin
        if (tap_rise) begin
          next_s.sclk  = 1'b1;
          next_s.sdata = s.shift[s.bit_cnt];
        end else if (tap_fall && s.sclk) begin
          next_s.sclk    = 1'b0;
          next_s.bit_cnt = s.bit_cnt + 2'h1;
          if (s.bit_cnt == sbt_pkg::LAST_BIT) begin
            if (s.mode == sbt_pkg::SBT_INTERACTIVE) begin
              if (s.tx_full) begin
                next_s.shift   = s.tx_nib;
                next_s.tx_full = 1'b0;
                ev_flag        = 1'b1;
                ev_irq         = 1'b1;
              end else begin
                next_s.mode   = sbt_pkg::SBT_IDLE;
                next_s.istart = 1'b0;
              end
            end else if (!s.from_ram || s.ram_addr != 6'(s.size + 6'h01)) begin
              next_s.shift    = ram_rdata;
              next_s.from_ram = 1'b1;
              next_s.ram_addr = s.ram_addr + 6'h01;
            end else begin
              next_s.mode        = sbt_pkg::SBT_IDLE;
              next_s.auto_sel    = 1'b0;
              ev_flag            = 1'b1;
              next_s.wake        = 1'b1;
              next_s.wake_vector = s.irq_seen || irq_request;
            end
          end
        end
        if (!s.sbe || (s.mode == sbt_pkg::SBT_INTERACTIVE && !s.istart)) begin
          next_s.mode = sbt_pkg::SBT_IDLE;
          next_s.sclk = 1'b0;
        end
      end
      default: begin
        next_s.mode = sbt_pkg::SBT_IDLE;
      end
    endcase

    // register writes; hardware set events below take priority over clears
    if (take_wr) begin
      case (avs_address)
        sbt_pkg::OFF_TX_NIBBLE: begin
          next_s.tx_nib    = wd;
          next_s.tx_full   = 1'b1;
          next_s.flag3     = 1'b0;
          next_s.empty_irq = 1'b0;
        end
        sbt_pkg::OFF_LENGTH_LOW: begin
          next_s.size[3:0] = wd;
        end
        sbt_pkg::OFF_LENGTH_HIGH: begin
          next_s.size[5:4] = wd[1:0];
          next_s.istart    = wd[sbt_pkg::BIT_ISTART];
          next_s.auto_sel  = wd[sbt_pkg::BIT_AUTO_SEL];
        end
        sbt_pkg::OFF_SERIAL_RATE: begin
          next_s.rate = wd[1:0];
          next_s.sbe  = wd[sbt_pkg::BIT_SBE];
        end
        default: begin
        end
      endcase
    end
    if (ev_flag) begin
      next_s.flag3 = 1'b1;
    end
    if (ev_irq) begin
      next_s.empty_irq = 1'b1;
    end

    // interrupt enable held off while auto select is set
    next_s.irq_block   = next_s.auto_sel;
    next_s.irq_restore = s.irq_block && !next_s.irq_block;
    next_s.oe          = next_s.sbe;
    if (take_rd) begin
      next_s.rdata = s.rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= sbt_pkg::SBT_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata       = s.rdata;
  assign avs_waitrequest    = s.wreq;
  assign global_irq_block   = s.irq_block;
  assign global_irq_restore = s.irq_restore;
  assign cpu_wake           = s.wake;
  assign cpu_wake_vector    = s.wake_vector;
  assign branch_test_flag3  = s.flag3;
  assign tx_empty_irq       = s.empty_irq;
  assign ram_addr           = s.ram_addr;
  assign pd0_sclk_out       = s.sclk;
  assign pd0_sclk_oe        = s.oe;
  assign pd1_sdata_out      = s.sdata;
  assign pd1_sdata_oe       = s.oe;

endmodule : sbt_serial_write_buffer

`default_nettype wire

// file: test/sbt_props.sv
`timescale 1ns/1ps
`default_nettype none
module sbt_props (
  // clock and bus
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [4:0] avs_address,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // cpu side
  input wire logic       global_irq_block,
  input wire logic       global_irq_restore,
  input wire logic       cpu_wake,
  input wire logic       branch_test_flag3,
  input wire logic       tx_empty_irq,
  // port D pins
  input wire logic       pd0_sclk_out,
  input wire logic       pd0_sclk_oe,
  input wire logic       pd1_sdata_out,
  input wire logic       pd1_sdata_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_tx_write;
    avs_write && !avs_waitrequest && avs_address == 5'h00;
  endsequence
  sequence s_auto_end;
    cpu_wake ##1 !cpu_wake;
  endsequence
  property p_wait; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_clear; s_tx_write |=> !tx_empty_irq && !branch_test_flag3; endproperty
  property p_rest; global_irq_restore |-> !global_irq_block; endproperty
  property p_wake; cpu_wake |-> s_auto_end; endproperty
  property p_end; cpu_wake |-> ##[0:1] (branch_test_flag3 && !global_irq_block); endproperty
  property p_oe; pd0_sclk_oe == pd1_sdata_oe; endproperty
  property p_data; $past(pd0_sclk_out) |-> $stable(pd1_sdata_out); endproperty
  property p_empty; $rose(tx_empty_irq) |-> branch_test_flag3; endproperty
  a_wait: assert property (p_wait) else $error("waitrequest low too long");
  a_clear: assert property (p_clear) else $error("empty or flag not cleared");
  a_rest: assert property (p_rest) else $error("restore while blocked");
  a_wake: assert property (p_wake) else $error("wake not a pulse");
  a_end: assert property (p_end) else $error("end state wrong");
  a_oe: assert property (p_oe) else $error("pin enables differ");
  a_data: assert property (p_data) else $error("data moved off rising clock");
  a_empty: assert property (p_empty) else $error("empty without flag");
endmodule : sbt_props
bind sbt_serial_write_buffer sbt_props i_props (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .global_irq_block(global_irq_block),
  .global_irq_restore(global_irq_restore), .cpu_wake(cpu_wake),
  .branch_test_flag3(branch_test_flag3), .tx_empty_irq(tx_empty_irq), .pd0_sclk_out(pd0_sclk_out),
  .pd0_sclk_oe(pd0_sclk_oe), .pd1_sdata_out(pd1_sdata_out), .pd1_sdata_oe(pd1_sdata_oe)
);
`default_nettype wire

// file: test/sbt_rx.sv
`timescale 1ns/1ps
`default_nettype none
module sbt_rx (
  // serial pins
  input wire logic sclk,
  input wire logic sdata
);
  logic [3:0] sh;
  logic [3:0] q [$];
  int         n = 0;
  int         per = 0;
  time        last = 0;
  // samples on falling clock, lsb first
  always @(negedge sclk) begin
    sh = {sdata, sh[3:1]};
    n = n + 1;
    per = int'($time - last);
    last = $time;
    if (n % 4 == 0) q.push_back(sh);
  end
endmodule : sbt_rx
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic        halt = 1'b0;
  logic        irq = 1'b0;
  logic [4:0]  tc = 5'h00;
  logic [31:0] rdat, r;
  logic        wreq, blk, wake, vec, f3, emp, soe, sclk, sd;
  logic [5:0]  ra;
  logic [3:0]  ram [64];
  logic [3:0]  exp_q [$];
  int          err_count = 0;
  int          n_checks = 0;
  wire logic [3:0] tap = {tc[0], tc[1], tc[3], tc[4]};
  always #10 clk = ~clk;
  initial begin
    #3;
    forever #80 tc = tc + 5'h01;
  end
  sbt_serial_write_buffer i_dut (
    .clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq), .ck_tap(tap),
    .cpu_halt(halt), .irq_request(irq), .global_irq_block(blk), .global_irq_restore(),
    .cpu_wake(wake), .cpu_wake_vector(vec), .branch_test_flag3(f3), .tx_empty_irq(emp),
    .ram_addr(ra), .ram_rdata(ram[ra]), .pd0_sclk_out(sclk), .pd0_sclk_oe(soe),
    .pd1_sdata_out(sd), .pd1_sdata_oe()
  );
  sbt_rx i_rx (.sclk(sclk), .sdata(sd));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [3:0] d);
    int t;
    t = 0;
    @(posedge clk);
    adr <= a;
    wd  <= {28'h0, d};
    rd  <= !w;
    wr  <= w;
    do @(posedge clk); while (wreq !== 1'b0 && ++t < 50);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (t == 50) err_count++;
  endtask : bus
  task automatic start_rx(input logic [3:0] nb);
    i_rx.q.delete();
    i_rx.n = 0;
    exp_q = {nb};
    bus(1'b1, 5'h00, nb);
  endtask : start_rx
  function automatic int exp_per(input logic [1:0] rt);
    case (rt)
      2'h0:    return 2560;
      2'h1:    return 1280;
      2'h2:    return 320;
      default: return 160;
    endcase
  endfunction : exp_per
  task automatic cmp_rx(input int per);
    chk(32'(i_rx.q.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) chk(32'(i_rx.q[i]), 32'(exp_q[i]));
    chk(32'(i_rx.per), 32'(per));
  endtask : cmp_rx
  task automatic auto_run(input logic [5:0] sz, input logic [1:0] rt);
    int t;
    t = 0;
    start_rx(4'($urandom));
    for (int i = 0; i <= sz; i++) exp_q.push_back(ram[i]);
    bus(1'b1, 5'h0c, {2'b10, rt});
    bus(1'b1, 5'h04, sz[3:0]);
    bus(1'b1, 5'h08, {2'b10, sz[5:4]});
    halt <= 1'b1;
    irq  <= 1'($urandom);
    @(posedge clk);
    halt <= 1'b0;
    chk(32'(blk), 32'h1);
    while (wake !== 1'b1 && t < 20000) begin
      @(posedge clk);
      t++;
    end
    if (t == 20000) err_count++;
    chk(32'(vec), 32'(irq));
    bus(1'b0, 5'h08, 4'h0);
    chk(32'(r[3]), 32'h0);
    chk(32'(f3), 32'h1);
    cmp_rx(exp_per(rt));
    bus(1'b1, 5'h00, 4'h0);
    @(posedge clk);
    chk(32'(f3), 32'h0);
    irq <= 1'b0;
  endtask : auto_run
  task automatic inter_run(input logic [1:0] rt, input int n);
    int t;
    logic [3:0] nb;
    bus(1'b1, 5'h0c, {2'b10, rt});
    start_rx(4'($urandom));
    bus(1'b1, 5'h08, 4'h4);
    for (int i = 1; i < n; i++) begin
      t = 0;
      while (emp !== 1'b1 && t < 2000) begin
        @(posedge clk);
        t++;
      end
      if (t == 2000) err_count++;
      chk(32'(f3), 32'h1);
      nb = 4'($urandom);
      exp_q.push_back(nb);
      bus(1'b1, 5'h00, nb);
      @(posedge clk);
      chk(32'(emp), 32'h0);
      if (rt[1]) bus(1'b1, 5'h08, 4'h4);
    end
    t = 0;
    do bus(1'b0, 5'h10, 4'h0); while (r[2] !== 1'b0 && ++t < 2000);
    if (t == 2000) err_count++;
    cmp_rx(exp_per(rt));
    bus(1'b1, 5'h00, 4'h0);
  endtask : inter_run
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    #2000000;
    err_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(14));
    foreach (ram[i]) ram[i] = 4'($urandom);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 5'h00, 4'h0);
    chk(r, 32'hf);
    bus(1'b1, 5'h14, 4'h5);
    bus(1'b0, 5'h14, 4'h0);
    chk(r, 32'h0);
    auto_run(6'h00, 2'h0);
    auto_run(6'($urandom_range(3, 1)), 2'h1);
    auto_run(6'($urandom_range(7, 1)), 2'h2);
    auto_run(6'h3e, 2'h3);
    auto_run(6'h3e, 2'h3);
    chk(32'(soe), 32'h1);
    inter_run(2'h0, 4);
    inter_run(2'h1, 3);
    inter_run(2'h2, 3);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
